// ===== hdl/rx_seq_ctrl_pkg.sv
// constants for the receive sequencing and interface control bank
package rx_seq_ctrl_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [6:0] MAIN_CONTROL_OFFSET = 7'h00;
  localparam logic [6:0] INTERFACE_CONFIG_OFFSET = 7'h01;

  // ****************************************************************
  // main control fields
  // ****************************************************************
  localparam int RX_TX_SELECT_BIT = 7;
  localparam int FREQ_BANK_BIT = 6;
  localparam int SCHEME_HI = 5;
  localparam int SCHEME_LO = 4;
  localparam int CAL_POLICY_HI = 3;
  localparam int CAL_POLICY_LO = 2;
  localparam int SYNTH_PD_BIT = 3;
  localparam int OSC_PD_BIT = 2;
  localparam int BIAS_POWER_DOWN_BIT = 1;
  localparam int SEQUENCE_SLEEP_BIT = 1;
  localparam int SOFT_RESET_N_BIT = 0;

  // ****************************************************************
  // interface config fields
  // ****************************************************************
  localparam int CRYSTAL_BYPASS_BIT = 7;
  localparam int SPLIT_DATA_PINS_BIT = 6;
  localparam int CLOCK_GATE_ON_PLL_BIT = 5;
  localparam int CLOCK_GATE_ON_CARRIER_BIT = 4;
  localparam int EXT_TX_AMP_CONTROL_BIT = 3;
  localparam int EXT_RX_AMP_CONTROL_BIT = 2;
  localparam int EXT_TX_AMP_POLARITY_BIT = 1;
  localparam int EXT_RX_AMP_POLARITY_BIT = 0;
  localparam int ANALOG_TEST_POWER_DOWN_BIT = 3;
  localparam int TEST_MODE_HI = 2;

  // ****************************************************************
  // values after reset
  // ****************************************************************
  localparam logic [7:0] MAIN_CONTROL_RESET = 8'h00;
  localparam logic [7:0] INTERFACE_CONFIG_RESET = 8'h00;
  localparam logic [7:0] SEQ_COUNT_RESET = 8'h00;
  localparam logic ANALOG_TEST_POWER_DOWN_FORCED = 1'h1;
  localparam logic [2:0] TEST_MODE_FORCED = 3'h1;

  // ****************************************************************
  // encodings
  // ****************************************************************
  typedef enum logic [1:0] {
    SCHEME_RX_OR_TX = 2'h0,
    SCHEME_BOTH_DOWN = 2'h1,
    SCHEME_INDIVIDUAL = 2'h2,
    SCHEME_SEQUENCING = 2'h3
  } power_down_scheme_t;

  typedef enum logic [1:0] {
    CAL_NEVER = 2'h0,
    CAL_EVERY = 2'h1,
    CAL_EVERY_16TH = 2'h2,
    CAL_EVERY_256TH = 2'h3
  } sequence_calibration_policy_t;

  localparam logic [3:0] CAL_16TH_LAST = 4'hF;
  localparam logic [7:0] CAL_256TH_LAST = 8'hFF;

endpackage : rx_seq_ctrl_pkg

// ===== hdl/seq_trigger_if.sv
// carrier between the control bank and its sequence trigger detector
`timescale 1ns/1ps
`default_nettype none
interface seq_trigger_if;
  logic sequencing_mode;
  logic split_data_pins;
  logic select_pin_starts_sequence;
  logic start;

  modport ctrl (
    output sequencing_mode,
    output split_data_pins,
    output select_pin_starts_sequence,
    input start
  );
  modport det (
    input sequencing_mode,
    input split_data_pins,
    input select_pin_starts_sequence,
    output start
  );
endinterface : seq_trigger_if
`default_nettype wire

// ===== hdl/seq_trigger.sv
// falling-edge start detector on the data and select pins
`timescale 1ns/1ps
`default_nettype none
module seq_trigger (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_data_io_pin,
  input wire logic i_select_pin_n,
  seq_trigger_if.det trig
);

  // ****************************************************************
  // pin synchronisers and edge history
  // ****************************************************************
  logic [2:0] dio_pipe;
  logic [2:0] sel_pipe;
  logic dio_fall;
  logic sel_fall;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      dio_pipe <= 3'h7;
      sel_pipe <= 3'h7;
    end else if (i_ce) begin
      dio_pipe <= {dio_pipe[1:0], i_data_io_pin};
      sel_pipe <= {sel_pipe[1:0], i_select_pin_n};
    end
  end

  assign dio_fall = dio_pipe[2] & ~dio_pipe[1];
  assign sel_fall = sel_pipe[2] & ~sel_pipe[1];

  // ****************************************************************
  // start pulse
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      trig.start <= 1'h0;
    end else if (i_ce) begin
      if (!trig.sequencing_mode) begin
        trig.start <= 1'h0;
      end else if (trig.select_pin_starts_sequence) begin
        trig.start <= sel_fall;
      end else begin
        trig.start <= trig.split_data_pins & dio_fall;
      end
    end
  end

endmodule : seq_trigger
`default_nettype wire

// ===== hdl/rx_sequencing_interface_control.sv
// main control and interface configuration registers with pin logic
`timescale 1ns/1ps
`default_nettype none
module rx_sequencing_interface_control (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [6:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_select_pin_starts_sequence,
  input wire logic i_test_filter_enable,
  input wire logic i_test_adc_enable,
  input wire logic i_sync_mode,
  input wire logic i_pll_lock,
  input wire logic i_carrier_sense,
  input wire logic i_rx_data,
  input wire logic i_rx_clk,
  input wire logic i_lock_indicator,
  input wire logic i_pa_on,
  input wire logic i_lna_on,
  input wire logic i_sequence_done,
  input wire logic i_data_io_pin,
  input wire logic i_select_pin_n,
  output logic [7:0] o_rd_data,
  output logic o_rx_tx_select,
  output logic o_freq_bank_b,
  output logic o_sequencing_enabled,
  output logic o_sequence_start,
  output logic o_sequence_sleep,
  output logic o_pll_cal_request,
  output logic o_synth_power_down,
  output logic o_oscillator_power_down,
  output logic o_bias_power_down,
  output logic o_soft_reset_n,
  output logic o_crystal_bypass,
  output logic o_data_io_out,
  output logic o_data_io_oe_n,
  output logic o_lock_pin,
  output logic o_data_clock_pin,
  output logic o_tx_amp_enable_pin,
  output logic o_rx_amp_enable_pin,
  output logic o_analog_test_power_down,
  output logic [2:0] o_test_mode
);

  // ****************************************************************
  // registers and decode
  // ****************************************************************
  logic [7:0] main_control;
  logic [7:0] interface_config;
  logic [7:0] seq_count;
  logic [1:0] pll_lock_sync;
  logic wr_main;
  logic wr_iface;
  logic seq_mode;
  logic test_override;
  logic gate_pll;
  logic gate_cs;
  logic split;
  logic next_cal;
  logic [1:0] scheme;
  seq_trigger_if trig ();

  function automatic logic amp_pin(input logic ext, input logic on,
                                   input logic pol);
    amp_pin = ext ? (on ? pol : ~pol) : pol;
  endfunction : amp_pin

  assign wr_main = i_wr_en && (i_addr == rx_seq_ctrl_pkg::MAIN_CONTROL_OFFSET);
  assign wr_iface = i_wr_en &&
                    (i_addr == rx_seq_ctrl_pkg::INTERFACE_CONFIG_OFFSET);
  assign scheme = main_control[rx_seq_ctrl_pkg::SCHEME_HI:
                               rx_seq_ctrl_pkg::SCHEME_LO];
  assign seq_mode = (scheme == rx_seq_ctrl_pkg::SCHEME_SEQUENCING) &&
                    !main_control[rx_seq_ctrl_pkg::RX_TX_SELECT_BIT];
  assign split = interface_config[rx_seq_ctrl_pkg::SPLIT_DATA_PINS_BIT];
  assign test_override = i_test_filter_enable | i_test_adc_enable;
  assign gate_pll = i_sync_mode && (scheme == rx_seq_ctrl_pkg::SCHEME_BOTH_DOWN)
                    && interface_config[rx_seq_ctrl_pkg::CLOCK_GATE_ON_PLL_BIT]
                    && !pll_lock_sync[1];
  assign gate_cs = i_sync_mode && !i_carrier_sense &&
                   interface_config[rx_seq_ctrl_pkg::CLOCK_GATE_ON_CARRIER_BIT];

  assign trig.sequencing_mode = seq_mode;
  assign trig.split_data_pins = split;
  assign trig.select_pin_starts_sequence = i_select_pin_starts_sequence;

  seq_trigger u_seq_trigger (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_data_io_pin(i_data_io_pin),
    .i_select_pin_n(i_select_pin_n),
    .trig(trig)
  );

  // ****************************************************************
  // main control: no soft default, written directly
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      main_control <= rx_seq_ctrl_pkg::MAIN_CONTROL_RESET;
    end else if (i_ce && wr_main) begin
      main_control <= i_wr_data;
    end
  end

  // ****************************************************************
  // interface config: defaults while soft reset held low
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      interface_config <= rx_seq_ctrl_pkg::INTERFACE_CONFIG_RESET;
    end else if (i_ce) begin
      if (!main_control[rx_seq_ctrl_pkg::SOFT_RESET_N_BIT]) begin
        interface_config <= rx_seq_ctrl_pkg::INTERFACE_CONFIG_RESET;
      end else if (wr_iface) begin
        interface_config <= i_wr_data;
      end
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rd_data <= 8'h00;
    end else if (i_ce && i_rd_en) begin
      if (i_addr == rx_seq_ctrl_pkg::MAIN_CONTROL_OFFSET) begin
        o_rd_data <= main_control;
      end else if (i_addr == rx_seq_ctrl_pkg::INTERFACE_CONFIG_OFFSET) begin
        o_rd_data <= interface_config;
      end else begin
        o_rd_data <= 8'h00;
      end
    end
  end

  // ****************************************************************
  // pll lock synchroniser
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pll_lock_sync <= 2'h0;
    end else if (i_ce) begin
      pll_lock_sync <= {pll_lock_sync[0], i_pll_lock};
    end
  end

  // ****************************************************************
  // sequencing: sleep, start, calibration policy
  // ****************************************************************
  always_comb begin
    next_cal = 1'h0;
    unique case (main_control[rx_seq_ctrl_pkg::CAL_POLICY_HI:
                              rx_seq_ctrl_pkg::CAL_POLICY_LO])
      rx_seq_ctrl_pkg::CAL_NEVER: next_cal = 1'h0;
      rx_seq_ctrl_pkg::CAL_EVERY: next_cal = 1'h1;
      rx_seq_ctrl_pkg::CAL_EVERY_16TH:
        next_cal = (seq_count[3:0] == rx_seq_ctrl_pkg::CAL_16TH_LAST);
      rx_seq_ctrl_pkg::CAL_EVERY_256TH:
        next_cal = (seq_count == rx_seq_ctrl_pkg::CAL_256TH_LAST);
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      seq_count <= rx_seq_ctrl_pkg::SEQ_COUNT_RESET;
      o_pll_cal_request <= 1'h0;
    end else if (i_ce) begin
      o_pll_cal_request <= 1'h0;
      if (seq_mode && i_sequence_done) begin
        seq_count <= seq_count + 8'h01;
        o_pll_cal_request <= next_cal;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_sequence_sleep <= 1'h0;
      o_sequence_start <= 1'h0;
    end else if (i_ce) begin
      o_sequence_sleep <= seq_mode && wr_main &&
        !main_control[rx_seq_ctrl_pkg::SEQUENCE_SLEEP_BIT] &&
        i_wr_data[rx_seq_ctrl_pkg::SEQUENCE_SLEEP_BIT];
      o_sequence_start <= trig.start;
    end
  end

  // ****************************************************************
  // main control decode to outputs
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rx_tx_select <= 1'h0;
      o_freq_bank_b <= 1'h0;
      o_sequencing_enabled <= 1'h0;
      o_synth_power_down <= 1'h0;
      o_oscillator_power_down <= 1'h0;
      o_bias_power_down <= 1'h0;
      o_soft_reset_n <= 1'h0;
    end else if (i_ce) begin
      o_rx_tx_select <= main_control[rx_seq_ctrl_pkg::RX_TX_SELECT_BIT];
      o_freq_bank_b <= main_control[rx_seq_ctrl_pkg::FREQ_BANK_BIT];
      o_sequencing_enabled <= seq_mode;
      o_synth_power_down <= !seq_mode &&
        main_control[rx_seq_ctrl_pkg::SYNTH_PD_BIT];
      o_oscillator_power_down <= !seq_mode &&
        main_control[rx_seq_ctrl_pkg::OSC_PD_BIT];
      o_bias_power_down <= !seq_mode &&
        main_control[rx_seq_ctrl_pkg::BIAS_POWER_DOWN_BIT];
      o_soft_reset_n <= main_control[rx_seq_ctrl_pkg::SOFT_RESET_N_BIT];
    end
  end

  // ****************************************************************
  // data pins and data clock
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_data_io_out <= 1'h0;
      o_data_io_oe_n <= 1'h1;
      o_lock_pin <= 1'h0;
      o_data_clock_pin <= 1'h1;
    end else if (i_ce) begin
      o_data_io_out <= i_rx_data;
      o_data_io_oe_n <= split ||
        main_control[rx_seq_ctrl_pkg::RX_TX_SELECT_BIT];
      o_lock_pin <= (split && i_sync_mode) ? i_rx_data
                                           : i_lock_indicator;
      if (split && !i_sync_mode) begin
        o_data_clock_pin <= i_rx_data;
      end else if (gate_pll || gate_cs) begin
        o_data_clock_pin <= 1'h1;
      end else begin
        o_data_clock_pin <= i_rx_clk;
      end
    end
  end

  // ****************************************************************
  // clock source, amplifier pins, analog test
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_crystal_bypass <= 1'h0;
      o_tx_amp_enable_pin <= 1'h0;
      o_rx_amp_enable_pin <= 1'h0;
      o_analog_test_power_down <= rx_seq_ctrl_pkg::ANALOG_TEST_POWER_DOWN_FORCED;
      o_test_mode <= rx_seq_ctrl_pkg::TEST_MODE_FORCED;
    end else if (i_ce) begin
      o_crystal_bypass <=
        interface_config[rx_seq_ctrl_pkg::CRYSTAL_BYPASS_BIT];
      o_tx_amp_enable_pin <= amp_pin(
        interface_config[rx_seq_ctrl_pkg::EXT_TX_AMP_CONTROL_BIT], i_pa_on,
        interface_config[rx_seq_ctrl_pkg::EXT_TX_AMP_POLARITY_BIT]);
      o_rx_amp_enable_pin <= amp_pin(
        interface_config[rx_seq_ctrl_pkg::EXT_RX_AMP_CONTROL_BIT], i_lna_on,
        interface_config[rx_seq_ctrl_pkg::EXT_RX_AMP_POLARITY_BIT]);
      if (test_override) begin
        o_analog_test_power_down <=
          interface_config[rx_seq_ctrl_pkg::ANALOG_TEST_POWER_DOWN_BIT];
        o_test_mode <= interface_config[rx_seq_ctrl_pkg::TEST_MODE_HI:0];
      end else begin
        o_analog_test_power_down <= rx_seq_ctrl_pkg::ANALOG_TEST_POWER_DOWN_FORCED;
        o_test_mode <= rx_seq_ctrl_pkg::TEST_MODE_FORCED;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  AST_SEQ_NEEDS_RX: assert property (
    i_ce && main_control[7] |=> !o_sequencing_enabled)
    else $error("sequencing enabled while transmit selected");
  AST_SEQ_SCHEME: assert property (
    i_ce && $past(i_ce) && $past(i_rst_n) && $past(scheme) == 2'h3 &&
    !$past(main_control[7]) |-> o_sequencing_enabled)
    else $error("scheme 3 in receive did not enable sequencing");
  AST_BANK: assert property (
    i_ce && wr_main ##1 i_ce ##1 1'b1 |->
    o_freq_bank_b == $past(i_wr_data[6], 2))
    else $error("frequency bank output does not follow write");
  AST_CAL_NEVER: assert property (
    i_ce && seq_mode && i_sequence_done && main_control[3:2] == 2'h0
    |=> !o_pll_cal_request)
    else $error("calibration requested under never policy");
  AST_SLEEP: assert property (
    i_ce && seq_mode && wr_main && !main_control[1] && i_wr_data[1]
    |=> o_sequence_sleep)
    else $error("rising sleep write gave no sleep pulse");
  AST_SOFT_RESET: assert property (
    i_ce && !main_control[0] |=> interface_config == 8'h00)
    else $error("interface config not cleared by soft reset");
  AST_DIO_INPUT: assert property (
    i_ce && split |=> o_data_io_oe_n)
    else $error("data pin driven while split");
  AST_CLK_GATE: assert property (
    i_ce && (gate_pll || gate_cs) && !split |=> o_data_clock_pin)
    else $error("gated data clock not held high");
  AST_TX_AMP_FIXED: assert property (
    i_ce && !interface_config[3] |=> o_tx_amp_enable_pin ==
    $past(interface_config[1]))
    else $error("transmit amp pin differs from polarity");
  AST_TEST_FORCED: assert property (
    i_ce && !test_override |=> o_analog_test_power_down && o_test_mode == 3'h1)
    else $error("test controls not forced");
  AST_POWER_DOWN_SEQ: assert property (
    i_ce && seq_mode |=> !o_synth_power_down && !o_bias_power_down)
    else $error("power-down bits acted in sequencing mode");

endmodule : rx_sequencing_interface_control
`default_nettype wire

// ===== dv/host_pin_model.sv
// host side of the data and chip select pins
`timescale 1ns/1ps
`default_nettype none
module host_pin_model (
  input wire logic i_data_io_oe_n,
  input wire logic i_data_io_out,
  input wire logic i_host_data,
  input wire logic i_host_select_n,
  output logic o_data_io_pin,
  output logic o_select_pin_n
);
  // ****************
  // pin levels
  // ****************
  // host drives data only while the device has let go of the pin
  assign o_data_io_pin = (i_data_io_oe_n === 1'h0) ? i_data_io_out
    : i_host_data;
  assign o_select_pin_n = i_host_select_n;
endmodule : host_pin_model
`default_nettype wire

// ===== dv/test_rx_sequencing_interface_control.sv
// self-checking bench for the receive sequencing control bank
`timescale 1ns/1ps
`default_nettype none
module test_rx_sequencing_interface_control;
  // ****************
  // signals
  // ****************
  logic i_clk = 1'h0, i_rst_n = 1'h0, i_ce = 1'h1, i_wr_en = 1'h0;
  logic i_rd_en = 1'h0, i_select_pin_starts_sequence = 1'h0;
  logic i_test_filter_enable = 1'h0, i_test_adc_enable = 1'h0;
  logic i_sync_mode = 1'h1, i_pll_lock = 1'h0, i_carrier_sense = 1'h0;
  logic i_rx_data = 1'h1, i_rx_clk = 1'h0, i_lock_indicator = 1'h1;
  logic i_pa_on = 1'h0, i_lna_on = 1'h0, i_sequence_done = 1'h0;
  logic [6:0] i_addr = 7'h00;
  logic [7:0] i_wr_data = 8'h00;
  logic host_data = 1'h1, host_sel_n = 1'h1, i_data_io_pin, i_select_pin_n;
  logic [7:0] o_rd_data, r, m;
  logic [2:0] o_test_mode, pd;
  logic o_rx_tx_select, o_freq_bank_b, o_sequencing_enabled;
  logic o_sequence_start, o_sequence_sleep, o_pll_cal_request;
  logic o_synth_power_down, o_oscillator_power_down, o_bias_power_down;
  logic o_soft_reset_n, o_crystal_bypass, o_data_io_out, o_data_io_oe_n;
  logic o_lock_pin, o_data_clock_pin, o_tx_amp_enable_pin, s, rd_d = 1'h0;
  logic o_rx_amp_enable_pin, o_analog_test_power_down;
  logic [7:0] pinv, exp_q[$];
  logic [31:0] seed = 32'h1912;
  int mismatches = 0, samples_checked = 0, cycles = 0, s0;
  int n_start = 0, n_sleep = 0, n_cal = 0, nd[4] = '{16, 3, 16, 256};
  logic [7:0] ncal[4] = '{8'h00, 8'h03, 8'h01, 8'h01};
  assign pd = {o_synth_power_down, o_oscillator_power_down,
    o_bias_power_down};
  assign pinv = {4'h0, o_data_io_oe_n, o_data_io_out, o_lock_pin,
    o_data_clock_pin};

  rx_sequencing_interface_control u_rx_sequencing_interface_control (
    .i_clk, .i_rst_n, .i_ce, .i_wr_en, .i_rd_en, .i_addr, .i_wr_data,
    .i_select_pin_starts_sequence, .i_test_filter_enable,
    .i_test_adc_enable, .i_sync_mode, .i_pll_lock, .i_carrier_sense,
    .i_rx_data, .i_rx_clk, .i_lock_indicator, .i_pa_on, .i_lna_on,
    .i_sequence_done, .i_data_io_pin, .i_select_pin_n, .o_rd_data,
    .o_rx_tx_select, .o_freq_bank_b, .o_sequencing_enabled,
    .o_sequence_start, .o_sequence_sleep, .o_pll_cal_request,
    .o_synth_power_down, .o_oscillator_power_down, .o_bias_power_down,
    .o_soft_reset_n, .o_crystal_bypass, .o_data_io_out, .o_data_io_oe_n,
    .o_lock_pin, .o_data_clock_pin, .o_tx_amp_enable_pin,
    .o_rx_amp_enable_pin, .o_analog_test_power_down, .o_test_mode);

  host_pin_model u_host_pin_model (.i_data_io_oe_n(o_data_io_oe_n),
    .i_data_io_out(o_data_io_out), .i_host_data(host_data),
    .i_host_select_n(host_sel_n), .o_data_io_pin(i_data_io_pin),
    .o_select_pin_n(i_select_pin_n));

  // ****************
  // helpers
  // ****************
  function automatic logic [7:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : xorshift

  task automatic chk(input string n, input logic [7:0] v, e);
    samples_checked++;
    if (v !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, v);
    end
  endtask : chk

  task automatic b(input string n, input logic v, e);
    chk(n, {7'h0, v}, {7'h0, e});
  endtask : b

  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : step

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_addr = a;
    i_wr_data = d;
    i_wr_en = 1'h1;
    step(1);
    i_wr_en = 1'h0;
    step(3);
  endtask : wr

  task automatic wm(input logic [7:0] d);
    wr(rx_seq_ctrl_pkg::MAIN_CONTROL_OFFSET, d);
  endtask : wm

  task automatic wi(input logic [7:0] d);
    wr(rx_seq_ctrl_pkg::INTERFACE_CONFIG_OFFSET, d);
  endtask : wi

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    i_addr = a;
    i_rd_en = 1'h1;
    exp_q.push_back(e);
    step(1);
    i_rd_en = 1'h0;
    step(2);
  endtask : rd

  // one falling edge on data (0) or chip select (1), then idle
  task automatic fall(input logic p);
    if (p) host_sel_n = 1'h0;
    else host_data = 1'h0;
    step(8);
    host_sel_n = 1'h1;
    host_data = 1'h1;
    step(8);
  endtask : fall

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  // ****************
  // clock, monitors
  // ****************
  always #20 i_clk = ~i_clk;

  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    n_start <= n_start + ((o_sequence_start === 1'h1) ? 1 : 0);
    n_sleep <= n_sleep + ((o_sequence_sleep === 1'h1) ? 1 : 0);
    n_cal <= n_cal + ((o_pll_cal_request === 1'h1) ? 1 : 0);
    if (cycles == 5000) begin
      mismatches++;
      give_verdict();
    end
  end

  always @(posedge i_clk) begin
    rd_d <= i_rd_en;
    if (rd_d) begin
      #2;
      chk("rd_data", o_rd_data, exp_q.pop_front());
    end
  end

  // ****************
  // tests
  // ****************
  initial begin
    repeat (12) @(posedge i_clk);
    #1;
    i_rst_n = 1'h1;
    b("soft_rst_n", o_soft_reset_n, 1'h0);
    b("analog_test_power_down", o_analog_test_power_down, 1'h1);
    chk("test_mode", {5'h0, o_test_mode}, 8'h01);
    rd(7'h01, 8'h00);
    rd(7'h7F, 8'h00);
    wi(8'hFF);
    rd(7'h01, 8'h00);
    wm(8'h01);
    b("soft_rst_n", o_soft_reset_n, 1'h1);
    rd(7'h00, 8'h01);
    $display("done reset");
    for (int i = 0; i < 32; i++) begin
      r = xorshift();
      i_pa_on = r[0];
      i_lna_on = r[1];
      i_test_filter_enable = i[4] & r[2];
      i_test_adc_enable = i[4] & (r[3] | ~r[2]);
      wi({r[7], 3'h0, i[3:0]});
      b("bypass", o_crystal_bypass, r[7]);
      if (i < 16) begin
        b("tx", o_tx_amp_enable_pin,
          i[3] ? r[0] ~^ i[1] : i[1]);
        b("rx", o_rx_amp_enable_pin,
          i[2] ? r[1] ~^ i[0] : i[0]);
        chk("tmode", {5'h0, o_test_mode}, 8'h01);
      end else begin
        b("tpd", o_analog_test_power_down, i[3]);
        chk("tmode", {5'h0, o_test_mode}, {5'h0, i[2:0]});
      end
    end
    $display("done interface");
    for (int i = 0; i < 8; i++) begin
      r = xorshift();
      m = {i[2], r[6], i[1:0], r[3:1], 1'h1};
      wm(m);
      rd(7'h00, m);
      s = ~m[7] & (m[5:4] == 2'h3);
      b("seq", o_sequencing_enabled, s);
      b("rx_tx_select", o_rx_tx_select, m[7]);
      b("bank", o_freq_bank_b, m[6]);
      chk("pd", {5'h0, pd}, s ? 8'h00 : {5'h0, m[3:1]});
    end
    wm(8'h31);
    s0 = n_sleep;
    wm(8'h33);
    wm(8'h33);
    wm(8'hB1);
    wm(8'hB3);
    chk("sleep", 8'(n_sleep - s0), 8'h01);
    $display("done main");
    for (int k = 0; k < 4; k++) begin
      i_select_pin_starts_sequence = (k == 1);
      wm(k == 2 ? 8'h21 : 8'h31);
      wi(k == 3 ? 8'h00 : 8'h40);
      b("oe_n", o_data_io_oe_n, k != 3);
      s0 = n_start;
      fall(1'h0);
      chk("start_d", 8'(n_start - s0), {7'h0, k == 0});
      s0 = n_start;
      fall(1'h1);
      chk("start_s", 8'(n_start - s0), {7'h0, k == 1});
    end
    $display("done trigger");
    for (int p = 0; p < 4; p++) begin
      wm({4'h3, p[1:0], 2'h1});
      s0 = n_cal;
      repeat (nd[p]) begin
        i_sequence_done = 1'h1;
        step(1);
        i_sequence_done = 1'h0;
        step(1);
      end
      step(2);
      chk("cal", 8'(n_cal - s0), ncal[p]);
    end
    $display("done calibration");
    wm(8'h01);
    wi(8'h00);
    chk("pins", pinv & 8'h0F, 8'h06);
    wi(8'h10);
    chk("pins", pinv & 8'h01, 8'h01);
    i_carrier_sense = 1'h1;
    step(2);
    chk("pins", pinv & 8'h01, 8'h00);
    wm(8'h11);
    wi(8'h20);
    chk("pins", pinv & 8'h01, 8'h01);
    i_pll_lock = 1'h1;
    step(4);
    chk("pins", pinv & 8'h01, 8'h00);
    wi(8'h40);
    chk("pins", pinv & 8'h0A, 8'h0A);
    i_rx_data = 1'h0;
    step(2);
    chk("pins", pinv & 8'h02, 8'h00);
    i_sync_mode = 1'h0;
    i_rx_data = 1'h1;
    step(2);
    chk("pins", pinv & 8'h09, 8'h09);
    i_sync_mode = 1'h1;
    wi(8'h00);
    wm(8'h81);
    chk("pins", pinv & 8'h08, 8'h08);
    $display("done pins");
    wi(8'hA5);
    wm(8'h80);
    rd(7'h01, 8'h00);
    b("soft_rst_n", o_soft_reset_n, 1'h0);
    wm(8'h81);
    rd(7'h01, 8'h00);
    // writes while the clock enable is low must be dropped
    i_ce = 1'h0;
    wm(8'h01);
    i_ce = 1'h1;
    rd(7'h00, 8'h81);
    $display("done soft reset and enable");
    give_verdict();
  end
endmodule : test_rx_sequencing_interface_control
`default_nettype wire
